// [dag_pkg.sv]
// Notes on behaviour
// R1: Two generators; first addresses data memory and may reverse, second data or program.
// R2: Each generator holds four cursor, four step and four size registers of 14 bits.
// R3: An indirect access emits the selected cursor as the memory address.
// R4: With reversal mode set, the first generator emits its address bit-reversed.
// R5: After each access the chosen step is added to the chosen cursor and stored. A bus load of that cursor in the same cycle is stored instead.
// R6: Any cursor pairs with any step of its own generator, never the other's.
// R7: Step values are signed two's complement, moving the cursor up or down.
// R8: Each cursor uses the size register of the same index for wraparound.
// R9: A zero size disables wraparound; the new cursor is cursor plus step.
// R10: A nonzero size wraps a cursor that would cross the buffer boundary.
// R11: Registers use the low 14 bus bits; cursor and size reads pad zeros.
// R12: Step reads copy the sign bit into the top two bus bits.
// R13: Buffer base is the cursor with its low N bits cleared, N from size.
// R14: Software places buffers at bases whose low N bits are zero.
// R15: Circular result is ((cursor + step - base) mod size) + base.
// R16: Software keeps step magnitude no larger than the buffer size.
// R17: Reversal mirrors the 14-bit address, output bit k taking input bit 13-k.
// R18: Only the emitted address is reversed; the stored cursor stays in order.
// R19: The new cursor is cut to 14 bits, so linear updates wrap around.
package dag_pkg;
  localparam int ADDR_BITS = 14;
  localparam int BUS_BITS = 16;
  localparam int PAD_BITS = 2;
  localparam int REGS_PER_FILE = 4;
  localparam int IDX_BITS = 2;
  localparam logic [1:0] FILE_CURSOR = 2'h0;
  localparam logic [1:0] FILE_STEP = 2'h1;
  localparam logic [1:0] FILE_SIZE = 2'h2;
  localparam logic [1:0] FILE_NONE = 2'h3;
  localparam logic UNIT_FIRST = 1'b0;
  localparam logic UNIT_SECOND = 1'b1;
  localparam logic [13:0] REG_RESET = 14'h0000;
  localparam logic [15:0] BUS_IDLE = 16'h0000;
  localparam int CLK_PERIOD_NS = 100;
  typedef logic [ADDR_BITS-1:0] addr_t;
  typedef logic [IDX_BITS-1:0] idx_t;
  typedef logic [BUS_BITS-1:0] word_t;
  typedef logic [1:0] file_t;
endpackage

// [dual_data_address_generator.sv]
`timescale 1ns/1ns
module dual_data_address_generator
  import dag_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_unit,
  input wire file_t bus_file,
  input wire idx_t bus_index,
  input wire word_t data_side_bus_in,
  output word_t data_side_bus_out,
  output logic data_side_bus_valid,
  input wire logic reverse_mode,
  input wire logic u1_access,
  input wire idx_t u1_cursor_sel,
  input wire idx_t u1_step_sel,
  input wire logic u2_access,
  input wire idx_t u2_cursor_sel,
  input wire idx_t u2_step_sel,
  input wire logic u2_to_program,
  output addr_t first_addr,
  output logic first_addr_valid,
  output addr_t second_addr,
  output logic second_dm_valid,
  output logic second_pm_valid
);
  typedef struct packed {
    addr_t addr1;
    logic addr1_valid;
    addr_t addr2;
    logic dm2_valid;
    logic pm2_valid;
  } top_state_s;

  top_state_s st_reg;
  top_state_s st_next;
  addr_t next1;
  addr_t next2;
  addr_t base1;
  addr_t base2;
  addr_t rev1;

  regfile_link_if link1 ();
  regfile_link_if link2 ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode to the first unit's register files
  assign link1.wr_en = bus_wr && (bus_unit == UNIT_FIRST);
  assign link1.wr_file = bus_file;
  assign link1.wr_idx = bus_index;
  assign link1.wr_data = data_side_bus_in[ADDR_BITS-1:0]; // see R11
  assign link1.rd_en = bus_rd && (bus_unit == UNIT_FIRST);
  assign link1.rd_file = bus_file;
  assign link1.rd_idx = bus_index;

  // Bus decode to the second unit's register files
  assign link2.wr_en = bus_wr && (bus_unit == UNIT_SECOND);
  assign link2.wr_file = bus_file;
  assign link2.wr_idx = bus_index;
  assign link2.wr_data = data_side_bus_in[ADDR_BITS-1:0]; // see R11
  assign link2.rd_en = bus_rd && (bus_unit == UNIT_SECOND);
  assign link2.rd_file = bus_file;
  assign link2.rd_idx = bus_index;

  // Each unit sees only its own selections, so steps never cross over
  assign link1.cur_sel = u1_cursor_sel;
  assign link1.step_sel = u1_step_sel; // see R6
  assign link1.upd_en = u1_access; // see R5
  assign link1.upd_value = next1; // see R18
  assign link2.cur_sel = u2_cursor_sel;
  assign link2.step_sel = u2_step_sel; // see R6
  assign link2.upd_en = u2_access; // see R5
  assign link2.upd_value = next2;

  ////////////////////////////////////////////////////////////////////////////
  // Register files, one per unit
  ptr_regfile u_rf1 (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .link(link1.store)
  );

  ptr_regfile u_rf2 (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .link(link2.store)
  );

  // Post-modify arithmetic, one per unit
  modulo_step #(
    .WIDTH(ADDR_BITS)
  ) u_step1 (
    .cursor(link1.cur_val),
    .step(link1.step_val),
    .size(link1.size_val),
    .next_cursor(next1),
    .base(base1)
  );

  modulo_step #(
    .WIDTH(ADDR_BITS)
  ) u_step2 (
    .cursor(link2.cur_val),
    .step(link2.step_val),
    .size(link2.size_val),
    .next_cursor(next2),
    .base(base2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mirror about the midpoint; only the first unit has this path
  for (genvar k = 0; k < ADDR_BITS; k++)
  begin : g_reverse
    assign rev1[k] = link1.cur_val[ADDR_BITS-1-k]; // see R17
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address registers hold their last value between accesses
  always_comb
  begin
    st_next = st_reg;
    st_next.addr1_valid = u1_access;
    st_next.dm2_valid = u2_access && !u2_to_program; // see R1
    st_next.pm2_valid = u2_access && u2_to_program; // see R1
    if (u1_access)
      st_next.addr1 = reverse_mode ? rev1 : link1.cur_val; // see R3 see R4
    if (u2_access)
      st_next.addr2 = link2.cur_val; // see R3
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; idle register file read data is zero, so OR merges them
  assign first_addr = st_reg.addr1;
  assign first_addr_valid = st_reg.addr1_valid;
  assign second_addr = st_reg.addr2;
  assign second_dm_valid = st_reg.dm2_valid;
  assign second_pm_valid = st_reg.pm2_valid;
  assign data_side_bus_out = link1.rd_data | link2.rd_data;
  assign data_side_bus_valid = link1.rd_valid | link2.rd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers read only by the checks below
  logic load_hits1;
  addr_t neg_step1;
  addr_t off1;
  addr_t off2;

  assign load_hits1 = link1.wr_en && bus_file == FILE_CURSOR && bus_index == u1_cursor_sel;
  assign neg_step1 = addr_t'(~link1.step_val + 14'h0001);
  assign off1 = addr_t'(link1.cur_val - base1);
  assign off2 = addr_t'(link2.cur_val - base2);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_rev_access;
    u1_access && reverse_mode && !load_hits1;
  endsequence

  // Same cursor still selected, so the stored value shows on the access path
  sequence s_same_cursor_again;
    u1_cursor_sel == $past(u1_cursor_sel);
  endsequence

  sequence s_step_read;
    bus_rd && bus_file == FILE_STEP;
  endsequence

  sequence s_unsigned_read;
    bus_rd && (bus_file == FILE_CURSOR || bus_file == FILE_SIZE);
  endsequence

  chk_first_addr_plain: assert property ( // see R3
    u1_access && !reverse_mode
    |=> first_addr_valid && first_addr == $past(link1.cur_val))
    else $error("first address is not the selected cursor");

  chk_first_addr_mirror: assert property ( // see R4
    u1_access && reverse_mode
    |=> first_addr[0] == $past(link1.cur_val[13]) && first_addr[13] == $past(link1.cur_val[0])
      && first_addr[6] == $past(link1.cur_val[7]) && first_addr[7] == $past(link1.cur_val[6]))
    else $error("reversed address not mirrored about the midpoint");

  chk_reverse_keeps_order: assert property ( // see R18
    s_rev_access ##1 s_same_cursor_again |-> link1.cur_val == $past(next1))
    else $error("stored cursor was bit-reversed");

  chk_second_no_reverse: assert property ( // see R1
    u2_access |=> second_addr == $past(link2.cur_val))
    else $error("second unit altered its address");

  chk_second_bus_choice: assert property ( // see R1
    u2_access |=> second_pm_valid == $past(u2_to_program) && second_dm_valid == !$past(u2_to_program))
    else $error("second unit drove the wrong memory");

  chk_second_exclusive: assert property ( // see R1
    !(second_dm_valid && second_pm_valid))
    else $error("second unit addressed both memories");

  chk_linear_plain: assert property ( // see R9
    u1_access && link1.size_val == '0 |-> next1 == addr_t'(link1.cur_val + link1.step_val))
    else $error("linear update is not the plain sum");

  chk_linear_wrap_space: assert property ( // see R19
    u2_access && link2.size_val == '0 && link2.cur_val == 14'h3fff && link2.step_val == 14'h0001
    |-> next2 == 14'h0000)
    else $error("linear update did not wrap the address space");

  chk_step_downward: assert property ( // see R7
    u1_access && link1.size_val == '0 && link1.step_val[13] && link1.cur_val >= neg_step1
    |-> next1 < link1.cur_val)
    else $error("negative step did not lower the cursor");

  chk_circ_inside1: assert property ( // see R10
    u1_access && link1.size_val != '0 && off1 < link1.size_val
    |-> next1 >= base1 && addr_t'(next1 - base1) < link1.size_val)
    else $error("first unit left its circular buffer");

  chk_circ_inside2: assert property ( // see R15
    u2_access && link2.size_val != '0 && off2 < link2.size_val
    |-> next2 >= base2 && addr_t'(next2 - base2) < link2.size_val)
    else $error("second unit left its circular buffer");

  chk_base_aligned: assert property ( // see R13
    u1_access && link1.size_val != '0
    |-> (base1 & ~link1.cur_val) == '0 && off1 <= {link1.size_val[ADDR_BITS-2:0], 1'b1})
    else $error("buffer base not the cursor with low bits cleared");

  chk_size_pairing: assert property ( // see R8
    u1_access && link1.size_val == '0 && u1_cursor_sel == u2_cursor_sel
    && !bus_wr && $stable(u1_cursor_sel) |-> link1.size_val == $past(link1.size_val))
    else $error("size selection does not follow the cursor");

  chk_unsigned_read: assert property ( // see R11
    s_unsigned_read |=> data_side_bus_valid && data_side_bus_out[15:14] == 2'h0)
    else $error("cursor or size read not zero padded");

  chk_step_sign_read: assert property ( // see R12
    s_step_read |=> data_side_bus_valid && data_side_bus_out[15:14] == {2{data_side_bus_out[13]}})
    else $error("step read not sign extended");

  chk_read_single: assert property ( // see R2
    !bus_rd |=> !data_side_bus_valid && data_side_bus_out == BUS_IDLE)
    else $error("bus read data without a read");
endmodule

// [ext_memories.sv]
`timescale 1ns/1ns
module ext_memories
  import dag_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire addr_t first_addr,
  input wire logic first_addr_valid,
  input wire addr_t second_addr,
  input wire logic second_dm_valid,
  input wire logic second_pm_valid,
  output addr_t dm_last_addr,
  output addr_t pm_last_addr,
  output logic [7:0] dm_count,
  output logic [7:0] pm_count
);
  ////////////////////////////////////////////////////////////////////////////
  // Memories only listen on the address buses; keep last address and counts
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dm_last_addr <= '0;
      pm_last_addr <= '0;
      dm_count <= 8'h00;
      pm_count <= 8'h00;
    end
    else
    begin
      if (first_addr_valid)
        dm_last_addr <= first_addr;
      if (second_dm_valid)
        dm_last_addr <= second_addr;
      if (second_pm_valid)
        pm_last_addr <= second_addr;
      // Both units may hit data memory in one cycle, so add both
      dm_count <= dm_count + 8'(first_addr_valid) + 8'(second_dm_valid);
      pm_count <= pm_count + 8'(second_pm_valid);
    end
  end
endmodule

// [modulo_step.sv]
`timescale 1ns/1ns
module modulo_step
  import dag_pkg::*;
#(
  parameter int WIDTH = ADDR_BITS
)
(
  input wire logic [WIDTH-1:0] cursor,
  input wire logic [WIDTH-1:0] step,
  input wire logic [WIDTH-1:0] size,
  output logic [WIDTH-1:0] next_cursor,
  output logic [WIDTH-1:0] base
);
  logic [WIDTH-1:0] mask;
  logic signed [WIDTH+1:0] offset;
  logic signed [WIDTH+1:0] size_ext;
  logic signed [WIDTH+1:0] wrapped;

  // Widths outside this range break the signed offset arithmetic
  if (WIDTH < 2 || WIDTH > 30)
  begin : g_width_check
    $error("modulo_step: WIDTH out of range");
  end

  // Smear the size downward: all ones from its top set bit down, 2^N - 1
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_mask
    assign mask[i] = |size[WIDTH-1:i];
  end

  assign base = cursor & ~mask; // see R13

  // Offset inside the buffer, one wrap at most since |step| <= size
  always_comb
  begin
    size_ext = $signed({2'b00, size});
    offset = $signed({2'b00, cursor & mask}) + $signed({{2{step[WIDTH-1]}}, step}); // see R7
    if (offset >= size_ext)
      wrapped = offset - size_ext; // see R10
    else if (offset < 0)
      wrapped = offset + size_ext; // see R10
    else
      wrapped = offset;
    if (size == '0)
      next_cursor = cursor + step; // see R9 see R19
    else
      next_cursor = base + wrapped[WIDTH-1:0]; // see R15
  end
endmodule

// [ptr_regfile.sv]
`timescale 1ns/1ns
module ptr_regfile
  import dag_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  regfile_link_if.store link
);
  typedef struct packed {
    logic [REGS_PER_FILE-1:0][ADDR_BITS-1:0] cursor;
    logic [REGS_PER_FILE-1:0][ADDR_BITS-1:0] step;
    logic [REGS_PER_FILE-1:0][ADDR_BITS-1:0] size;
    word_t rd_data;
    logic rd_valid;
  } rf_state_s;

  rf_state_s st_reg;
  rf_state_s st_next;

  ////////////////////////////////////////////////////////////////////////////
  // Bus load wins over post-modify on the same cursor: software intent first
  always_comb
  begin
    st_next = st_reg;
    st_next.rd_valid = link.rd_en;
    st_next.rd_data = BUS_IDLE;
    if (link.rd_en)
    begin
      unique case (link.rd_file)
        FILE_CURSOR: st_next.rd_data = {{PAD_BITS{1'b0}}, st_reg.cursor[link.rd_idx]}; // see R11
        FILE_STEP: st_next.rd_data = {{PAD_BITS{st_reg.step[link.rd_idx][ADDR_BITS-1]}},
          st_reg.step[link.rd_idx]}; // see R12
        FILE_SIZE: st_next.rd_data = {{PAD_BITS{1'b0}}, st_reg.size[link.rd_idx]}; // see R11
        FILE_NONE: st_next.rd_data = BUS_IDLE;
      endcase
    end
    if (link.upd_en)
      st_next.cursor[link.cur_sel] = link.upd_value; // see R5
    if (link.wr_en)
    begin
      unique case (link.wr_file)
        FILE_CURSOR: st_next.cursor[link.wr_idx] = link.wr_data; // see R2
        FILE_STEP: st_next.step[link.wr_idx] = link.wr_data; // see R2
        FILE_SIZE: st_next.size[link.wr_idx] = link.wr_data; // see R2
        FILE_NONE: st_next.rd_valid = link.rd_en;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Access path is plain register content, no read latency
  assign link.cur_val = st_reg.cursor[link.cur_sel];
  assign link.step_val = st_reg.step[link.step_sel]; // see R6
  assign link.size_val = st_reg.size[link.cur_sel]; // see R8
  assign link.rd_data = st_reg.rd_data;
  assign link.rd_valid = st_reg.rd_valid;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  chk_update_writeback: assert property ( // see R5
    link.upd_en && !(link.wr_en && link.wr_file == FILE_CURSOR && link.wr_idx == link.cur_sel)
    |=> st_reg.cursor[$past(link.cur_sel)] == $past(link.upd_value))
    else $error("cursor not written back after access");

  chk_bus_load_step: assert property ( // see R2
    link.wr_en && link.wr_file == FILE_STEP
    |=> st_reg.step[$past(link.wr_idx)] == $past(link.wr_data))
    else $error("step register did not load from bus");

  chk_idle_cursors: assert property ( // see R6
    !link.upd_en && !link.wr_en |=> $stable(st_reg.cursor))
    else $error("cursor changed without access or write");
endmodule

// [regfile_link_if.sv]
`timescale 1ns/1ns
interface regfile_link_if;
  import dag_pkg::*;
  logic wr_en;
  file_t wr_file;
  idx_t wr_idx;
  addr_t wr_data;
  logic rd_en;
  file_t rd_file;
  idx_t rd_idx;
  word_t rd_data;
  logic rd_valid;
  logic upd_en;
  addr_t upd_value;
  idx_t cur_sel;
  idx_t step_sel;
  addr_t cur_val;
  addr_t step_val;
  addr_t size_val;
  modport owner (output wr_en, wr_file, wr_idx, wr_data, rd_en, rd_file, rd_idx, upd_en, upd_value,
    cur_sel, step_sel, input rd_data, rd_valid, cur_val, step_val, size_val);
  modport store (input wr_en, wr_file, wr_idx, wr_data, rd_en, rd_file, rd_idx, upd_en, upd_value,
    cur_sel, step_sel, output rd_data, rd_valid, cur_val, step_val, size_val);
endinterface

// [testbench.sv]
`timescale 1ns/1ns
`define CHK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", name, exp, got); end end
module testbench
  import dag_pkg::*;
;
  logic sys_clk, rst_b, bus_wr, bus_rd, bus_unit, data_side_bus_valid, reverse_mode;
  logic u1_access, u2_access, u2_to_program, first_addr_valid, second_dm_valid, second_pm_valid;
  file_t bus_file;
  idx_t bus_index, u1_cursor_sel, u1_step_sel, u2_cursor_sel, u2_step_sel;
  word_t data_side_bus_in, data_side_bus_out;
  addr_t first_addr, second_addr, dm_last_addr, pm_last_addr;
  logic [7:0] dm_count, pm_count;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  dual_data_address_generator dut (.sys_clk(sys_clk), .rst_b(rst_b), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_unit(bus_unit), .bus_file(bus_file), .bus_index(bus_index), .data_side_bus_in(data_side_bus_in),
    .data_side_bus_out(data_side_bus_out), .data_side_bus_valid(data_side_bus_valid),
    .reverse_mode(reverse_mode), .u1_access(u1_access), .u1_cursor_sel(u1_cursor_sel),
    .u1_step_sel(u1_step_sel), .u2_access(u2_access), .u2_cursor_sel(u2_cursor_sel),
    .u2_step_sel(u2_step_sel), .u2_to_program(u2_to_program), .first_addr(first_addr),
    .first_addr_valid(first_addr_valid), .second_addr(second_addr), .second_dm_valid(second_dm_valid),
    .second_pm_valid(second_pm_valid));

  ext_memories mem (.sys_clk(sys_clk), .rst_b(rst_b), .first_addr(first_addr),
    .first_addr_valid(first_addr_valid), .second_addr(second_addr), .second_dm_valid(second_dm_valid),
    .second_pm_valid(second_pm_valid), .dm_last_addr(dm_last_addr), .pm_last_addr(pm_last_addr),
    .dm_count(dm_count), .pm_count(pm_count));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the run needs well under a thousand cycles
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register bus cycles, inputs changed on the falling edge only
  task automatic reg_wr(input logic u, input file_t f, input idx_t i, input word_t d);
    @(negedge sys_clk);
    bus_wr = 1'b1;
    bus_unit = u;
    bus_file = f;
    bus_index = i;
    data_side_bus_in = d;
    @(negedge sys_clk);
    bus_wr = 1'b0;
  endtask

  // Read answer stands one cycle, so it is judged in that cycle
  task automatic reg_rd(input logic u, input file_t f, input idx_t i, input word_t exp);
    @(negedge sys_clk);
    bus_rd = 1'b1;
    bus_unit = u;
    bus_file = f;
    bus_index = i;
    @(negedge sys_clk);
    bus_rd = 1'b0;
    `CHK("read valid", 1'b1, data_side_bus_valid)
    `CHK("read data", exp, data_side_bus_out)
  endtask

  // One indirect access per entry of seq; checks address and memory select
  task automatic acc_seq(input logic u, input idx_t c, input idx_t s, input logic pm, input addr_t seq[$]);
    foreach (seq[k])
    begin
      @(negedge sys_clk);
      u1_access = !u;
      u2_access = u;
      u1_cursor_sel = c;
      u2_cursor_sel = c;
      u1_step_sel = s;
      u2_step_sel = s;
      u2_to_program = pm;
      @(negedge sys_clk);
      u1_access = 1'b0;
      u2_access = 1'b0;
      `CHK("address", seq[k], (u ? second_addr : first_addr))
      `CHK("valids", (u ? {1'b0, !pm, pm} : 3'b100), {first_addr_valid, second_dm_valid, second_pm_valid})
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    for (int u = 0; u < 2; u++)
      for (int f = 0; f < 4; f++)
        for (int i = 0; i < 4; i++)
          reg_rd(u[0], f[1:0], i[1:0], 16'h0000);
    $display("test reset_values done");
  endtask

  task automatic t_regs();
    reg_wr(1'b0, FILE_CURSOR, 2'h2, 16'hffff);
    reg_rd(1'b0, FILE_CURSOR, 2'h2, 16'h3fff);
    reg_wr(1'b1, FILE_STEP, 2'h3, 16'h2001);
    reg_rd(1'b1, FILE_STEP, 2'h3, 16'he001);
    reg_wr(1'b1, FILE_STEP, 2'h0, 16'hdfff);
    reg_rd(1'b1, FILE_STEP, 2'h0, 16'h1fff);
    reg_wr(1'b1, FILE_SIZE, 2'h2, 16'hc005);
    reg_rd(1'b1, FILE_SIZE, 2'h2, 16'h0005);
    reg_wr(1'b0, FILE_NONE, 2'h1, 16'h1234);
    reg_rd(1'b0, FILE_NONE, 2'h1, 16'h0000);
    $display("test register_access done");
  endtask

  // Linear update wraps at the 14-bit limit and moves both ways
  task automatic t_linear();
    reg_wr(1'b0, FILE_CURSOR, 2'h0, 16'h3ffe);
    reg_wr(1'b0, FILE_STEP, 2'h0, 16'h0003);
    reg_wr(1'b0, FILE_STEP, 2'h1, 16'h3fff);
    acc_seq(1'b0, 2'h0, 2'h0, 1'b0, '{14'h3ffe, 14'h0001, 14'h0004});
    acc_seq(1'b0, 2'h0, 2'h1, 1'b0, '{14'h0007, 14'h0006});
    reg_rd(1'b0, FILE_CURSOR, 2'h0, 16'h0005);
    // Second unit runs off the top of the address space too
    reg_wr(1'b1, FILE_CURSOR, 2'h0, 16'h3fff);
    reg_wr(1'b1, FILE_STEP, 2'h1, 16'h0001);
    acc_seq(1'b1, 2'h0, 2'h1, 1'b0, '{14'h3fff, 14'h0000});
    $display("test linear_update done");
  endtask

  // Software keeps bases aligned and steps within the length
  task automatic t_circular();
    reg_wr(1'b1, FILE_CURSOR, 2'h1, 16'h0005);
    reg_wr(1'b1, FILE_STEP, 2'h1, 16'h0001);
    reg_wr(1'b1, FILE_SIZE, 2'h1, 16'h0003);
    acc_seq(1'b1, 2'h1, 2'h1, 1'b0, '{14'h0005, 14'h0006, 14'h0004, 14'h0005});
    reg_wr(1'b0, FILE_CURSOR, 2'h3, 16'h0009);
    reg_wr(1'b0, FILE_STEP, 2'h2, 16'h3ffe);
    reg_wr(1'b0, FILE_SIZE, 2'h3, 16'h0005);
    // Unit two step 2 differs, so a cross-unit step would show
    reg_wr(1'b1, FILE_STEP, 2'h2, 16'h0001);
    acc_seq(1'b0, 2'h3, 2'h2, 1'b0, '{14'h0009, 14'h000c, 14'h000a, 14'h0008, 14'h000b});
    $display("test circular_update done");
  endtask

  // Only unit one reverses, and only on the emitted address
  task automatic t_reverse();
    reverse_mode = 1'b1;
    reg_wr(1'b0, FILE_CURSOR, 2'h1, 16'h0001);
    reg_wr(1'b0, FILE_STEP, 2'h3, 16'h0044);
    acc_seq(1'b0, 2'h1, 2'h3, 1'b0, '{14'h2000, 14'h2880});
    reg_rd(1'b0, FILE_CURSOR, 2'h1, 16'h0089);
    acc_seq(1'b1, 2'h1, 2'h1, 1'b1, '{14'h0006});
    reverse_mode = 1'b0;
    // Memory model registers the last valid one edge later
    @(negedge sys_clk);
    `CHK("program address", 14'h0006, pm_last_addr)
    `CHK("program count", 8'h01, pm_count)
    `CHK("data count", 8'h12, dm_count)
    $display("test bit_reverse done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_unit = 1'b0;
    bus_file = FILE_CURSOR;
    bus_index = 2'h0;
    data_side_bus_in = 16'h0000;
    reverse_mode = 1'b0;
    u1_access = 1'b0;
    u2_access = 1'b0;
    u1_cursor_sel = 2'h0;
    u1_step_sel = 2'h0;
    u2_cursor_sel = 2'h0;
    u2_step_sel = 2'h0;
    u2_to_program = 1'b0;
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    t_reset();
    t_regs();
    t_linear();
    t_circular();
    t_reverse();
    finish_test();
  end
endmodule
